// >>> hdl/dual_timebase_acquisition.sv
`timescale 1ns/10ps
// Functional notes
// - each trigger with no segment active and pretrigger filled stores one fast segment at full rate around the trigger
// - slow sampling runs unbroken all acquisition; sampling clock never switched
// - one slow sample every divider count of sampling clocks
// - divider 8..131064 step 8, or 16..262128 step 16 on 8 bit boards
// - segment length is total samples per trigger including pretrigger
// - after-trigger count is samples stored after each trigger
// - pretrigger equals segment length minus after-trigger count
// - pretrigger above channel-dependent limit rejects setup with length error
// - standard mode fills one segment-length block per trigger
// - standard mode stores whole segments until total sample count is reached, then finishes
// - mode code 80h selects continuous dual timebase recording
// - continuous mode runs until stop or until the segment count is reached, delivering data segment by segment
// - segment count 0 means endless, otherwise stop after that many segments
// - lengths in steps of 8, segment at least 16, after-trigger at least 8
module dual_timebase_acquisition
  import dual_timebase_pkg::*;
#(
  parameter bit NARROW_BOARD = 1'b0,
  parameter int PRE_DEPTH    = 8192
) (
  input  wire logic                sys_clk,
  input  wire logic                reset,
  input  wire logic                reg_write,
  input  wire logic                reg_read,
  input  wire logic [15:0]         reg_addr,
  input  wire logic [63:0]         reg_wdata,
  output logic      [63:0]         reg_rdata,
  output logic                     reg_rvalid,
  input  wire logic                start_cmd,
  input  wire logic                stop_cmd,
  input  wire logic                two_channels,
  input  wire logic                trigger,
  input  wire logic [SAMPLE_W-1:0] sample_in,
  output sample_beat_s             fast_out,
  output sample_beat_s             slow_out,
  output logic                     running,
  output logic                     pretrigger_length_error
);

  localparam int PW = $clog2(PRE_DEPTH);

  if (PRE_DEPTH < 8192 || (1 << PW) != PRE_DEPTH) begin : g_depth_check
    $error("PRE_DEPTH must be a power of two of at least 8192");
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks shared by setup and assertions

  function automatic logic divider_ok(input logic [31:0] div);
    logic [31:0] lo;
    logic [31:0] hi;
    logic        aligned;
    lo      = NARROW_BOARD ? DIV_MIN_NARROW : DIV_MIN_WIDE;
    hi      = NARROW_BOARD ? DIV_MAX_NARROW : DIV_MAX_WIDE;
    aligned = NARROW_BOARD ? (div[3:0] == 4'h0) : (div[2:0] == 3'h0);
    return aligned && div >= lo && div <= hi;
  endfunction : divider_ok

  function automatic logic step_ok(input logic [63:0] v);
    return v[2:0] == 3'h0;
  endfunction : step_ok

  ////////////////////////////////////////////////////////////////////////////
  // registers

  logic [31:0] operating_mode_reg;
  logic [63:0] total_sample_count_reg;
  logic [63:0] fast_segment_length_reg;
  logic [63:0] segment_count_reg;
  logic [63:0] after_trigger_samples_reg;
  logic [31:0] slow_rate_divider_reg;
  acq_state_e  state_reg;
  logic        divider_error_reg;
  logic        setup_error_reg;
  logic        pretrig_error_reg;

  // writes during a run are dropped so the live setup cannot tear
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      operating_mode_reg        <= MODE_RESET;
      total_sample_count_reg    <= TOTAL_RESET;
      fast_segment_length_reg   <= SEGMENT_RESET;
      segment_count_reg         <= COUNT_RESET;
      after_trigger_samples_reg <= AFTER_RESET;
      slow_rate_divider_reg     <= DIVIDER_RESET;
    end else if (reg_write && state_reg != ACQ_RUN) begin
      if (reg_addr == OPERATING_MODE_OFS) begin
        operating_mode_reg <= reg_wdata[31:0];
      end else if (reg_addr == TOTAL_SAMPLE_OFS) begin
        total_sample_count_reg <= reg_wdata;
      end else if (reg_addr == SEGMENT_LENGTH_OFS) begin
        fast_segment_length_reg <= reg_wdata;
      end else if (reg_addr == SEGMENT_COUNT_OFS) begin
        segment_count_reg <= reg_wdata;
      end else if (reg_addr == AFTER_TRIGGER_OFS) begin
        after_trigger_samples_reg <= reg_wdata;
      end else if (reg_addr == SLOW_DIVIDER_OFS) begin
        slow_rate_divider_reg <= reg_wdata[31:0];
      end
    end
  end

  logic [63:0] status_word;
  assign status_word = {59'h0, setup_error_reg, divider_error_reg, pretrig_error_reg,
                        state_reg == ACQ_DONE, state_reg == ACQ_RUN};

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      reg_rdata  <= 64'h0;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_read;
      if (reg_addr == OPERATING_MODE_OFS) begin
        reg_rdata <= {32'h0, operating_mode_reg};
      end else if (reg_addr == TOTAL_SAMPLE_OFS) begin
        reg_rdata <= total_sample_count_reg;
      end else if (reg_addr == SEGMENT_LENGTH_OFS) begin
        reg_rdata <= fast_segment_length_reg;
      end else if (reg_addr == SEGMENT_COUNT_OFS) begin
        reg_rdata <= segment_count_reg;
      end else if (reg_addr == AFTER_TRIGGER_OFS) begin
        reg_rdata <= after_trigger_samples_reg;
      end else if (reg_addr == SLOW_DIVIDER_OFS) begin
        reg_rdata <= {32'h0, slow_rate_divider_reg};
      end else if (reg_addr == ACQ_STATUS_OFS) begin
        reg_rdata <= status_word;
      end else begin
        reg_rdata <= 64'h0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // setup validation at start

  logic        fifo_mode;
  logic        mode_ok;
  logic [63:0] pre_calc;
  logic [63:0] pre_limit;
  logic        pre_bad;
  logic        div_bad;
  logic        setup_bad;

  assign fifo_mode = operating_mode_reg == CONTINUOUS_DUAL_TIMEBASE;
  assign mode_ok   = fifo_mode || operating_mode_reg == STANDARD_DUAL_TIMEBASE;
  assign pre_calc  = fast_segment_length_reg - after_trigger_samples_reg;
  assign pre_limit = two_channels ? PRE_MAX_TWO_CH : PRE_MAX_ONE_CH;
  assign pre_bad   = after_trigger_samples_reg > fast_segment_length_reg
                     || pre_calc < PRE_MIN || pre_calc > pre_limit;
  assign div_bad   = !divider_ok(slow_rate_divider_reg);
  assign setup_bad = !mode_ok || fast_segment_length_reg < SEGMENT_MIN
                     || after_trigger_samples_reg < AFTER_MIN
                     || !step_ok(fast_segment_length_reg)
                     || !step_ok(after_trigger_samples_reg)
                     || (!fifo_mode && (!step_ok(total_sample_count_reg)
                         || total_sample_count_reg < SEGMENT_MIN));

  logic        start_ok;
  logic        run_fifo;
  logic [63:0] run_pre;
  logic [17:0] run_div;
  logic        finish;

  assign start_ok = start_cmd && state_reg != ACQ_RUN && !pre_bad && !div_bad && !setup_bad;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pretrig_error_reg <= 1'b0;
      divider_error_reg <= 1'b0;
      setup_error_reg   <= 1'b0;
    end else if (start_cmd && state_reg != ACQ_RUN) begin
      pretrig_error_reg <= pre_bad;
      divider_error_reg <= div_bad;
      setup_error_reg   <= setup_bad;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_reg <= ACQ_IDLE;
      run_fifo  <= 1'b0;
      run_pre   <= 64'h0;
      run_div   <= 18'h0;
    end else begin
      case (state_reg)
        ACQ_IDLE, ACQ_DONE: begin
          if (start_ok) begin
            state_reg <= ACQ_RUN;
            run_fifo  <= fifo_mode;
            run_pre   <= pre_calc;
            run_div   <= slow_rate_divider_reg[17:0];
          end
        end
        ACQ_RUN: begin
          if (stop_cmd || finish) begin
            state_reg <= ACQ_DONE;
          end
        end
        default: state_reg <= ACQ_IDLE;
      endcase
    end
  end

  assign running                 = state_reg == ACQ_RUN;
  assign pretrigger_length_error = pretrig_error_reg;

  ////////////////////////////////////////////////////////////////////////////
  // slow timebase: a count on the one sampling clock, never a second clock

  logic [17:0] slow_cnt;

  always_ff @(posedge sys_clk) begin
    if (reset || state_reg != ACQ_RUN) begin
      slow_cnt <= 18'h0;
      slow_out <= '0;
    end else begin
      slow_out.valid <= slow_cnt == 18'h0;
      slow_out.last  <= 1'b0;
      slow_out.data  <= sample_in;
      slow_cnt       <= (slow_cnt == run_div - 18'h1) ? 18'h0 : slow_cnt + 18'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // fast segments: a history ring delays the input by the pretrigger length

  logic [SAMPLE_W-1:0] history [PRE_DEPTH];
  logic [PW-1:0]       wr_ptr;
  logic [PW:0]         fill;
  logic                seg_active;
  logic [63:0]         seg_left;
  logic [63:0]         segs_done;
  logic [63:0]         stored;
  logic                emit;
  logic                emit_last;
  logic [PW-1:0]       rd_ptr;
  logic                armed;

  assign rd_ptr = wr_ptr - run_pre[PW-1:0];
  assign armed  = {{(63-PW){1'b0}}, fill} >= run_pre;
  assign emit   = state_reg == ACQ_RUN && seg_active;
  assign emit_last = emit && seg_left == 64'h1;
  assign finish = emit_last && (run_fifo ? (segment_count_reg != 64'h0
                                            && segs_done + 64'h1 == segment_count_reg)
                                         : stored + 64'h1 >= total_sample_count_reg);

  always_ff @(posedge sys_clk) begin
    history[wr_ptr] <= sample_in;
  end

  // before the pretrigger has filled, triggers are ignored
  always_ff @(posedge sys_clk) begin
    if (reset || state_reg != ACQ_RUN) begin
      wr_ptr     <= '0;
      fill       <= '0;
      seg_active <= 1'b0;
      seg_left   <= 64'h0;
      segs_done  <= 64'h0;
      stored     <= 64'h0;
    end else begin
      wr_ptr <= wr_ptr + 1'b1;
      if (fill != PRE_DEPTH[PW:0]) begin
        fill <= fill + 1'b1;
      end
      if (!seg_active && trigger && armed) begin
        seg_active <= 1'b1;
        seg_left   <= fast_segment_length_reg;
      end else if (emit) begin
        seg_left <= seg_left - 64'h1;
        stored   <= stored + 64'h1;
        if (emit_last) begin
          seg_active <= 1'b0;
          segs_done  <= segs_done + 64'h1;
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      fast_out <= '0;
    end else begin
      fast_out.valid <= emit;
      fast_out.last  <= emit_last;
      fast_out.data  <= history[rd_ptr];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  logic [63:0] beats_seen;
  logic [17:0] slow_gap;
  logic        gap_armed;

  always_ff @(posedge sys_clk) begin
    if (reset || state_reg != ACQ_RUN) begin
      beats_seen <= 64'h0;
      slow_gap   <= 18'h0;
      gap_armed  <= 1'b0;
    end else begin
      beats_seen <= fast_out.valid ? (fast_out.last ? 64'h0 : beats_seen + 64'h1) : beats_seen;
      slow_gap   <= slow_out.valid ? 18'h1 : slow_gap + 18'h1;
      gap_armed  <= gap_armed || slow_out.valid;
    end
  end

  chk_slow_spacing: assert property (@(posedge sys_clk) disable iff (reset)
    running && slow_out.valid && gap_armed |-> slow_gap == run_div)
    else $error("slow sample spacing differs from divider");

  chk_slow_min_gap: assert property (@(posedge sys_clk) disable iff (reset)
    slow_out.valid |=> !slow_out.valid [*7])
    else $error("slow samples closer than minimum divider");

  chk_slow_during_seg: assert property (@(posedge sys_clk) disable iff (reset)
    running && seg_active && $past(running) |-> slow_cnt != $past(slow_cnt))
    else $error("slow count stalled during fast segment");

  chk_segment_length: assert property (@(posedge sys_clk) disable iff (reset)
    fast_out.valid && fast_out.last |-> beats_seen + 64'h1 == fast_segment_length_reg)
    else $error("fast segment length wrong");

  chk_pre_derived: assert property (@(posedge sys_clk) disable iff (reset)
    running |-> run_pre == fast_segment_length_reg - after_trigger_samples_reg)
    else $error("pretrigger not segment minus after-trigger");

  chk_pretrig_reject: assert property (@(posedge sys_clk) disable iff (reset)
    start_cmd && !running && pre_bad |=> pretrigger_length_error && !running)
    else $error("bad pretrigger not rejected");

  chk_divider_reject: assert property (@(posedge sys_clk) disable iff (reset)
    start_cmd && !running && div_bad |=> divider_error_reg && !running)
    else $error("bad divider not rejected");

  chk_std_total: assert property (@(posedge sys_clk) disable iff (reset)
    running && !run_fifo && emit_last && stored + 64'h1 >= total_sample_count_reg
    |=> state_reg == ACQ_DONE ##1 !fast_out.valid)
    else $error("standard run did not finish at total count");

  chk_fifo_endless: assert property (@(posedge sys_clk) disable iff (reset)
    running && run_fifo && segment_count_reg == 64'h0 && !stop_cmd |=> running)
    else $error("endless continuous run ended without stop");

  chk_mode_code: assert property (@(posedge sys_clk) disable iff (reset)
    start_ok && operating_mode_reg == CONTINUOUS_DUAL_TIMEBASE |=> run_fifo && running)
    else $error("code 80h did not start continuous mode");

  cov_segment_done: cover property (@(posedge sys_clk) disable iff (reset)
    fast_out.valid && fast_out.last);
  cov_fifo_count_end: cover property (@(posedge sys_clk) disable iff (reset)
    running && run_fifo ##1 state_reg == ACQ_DONE);
  cov_pretrig_err: cover property (@(posedge sys_clk) disable iff (reset)
    pretrigger_length_error);

endmodule : dual_timebase_acquisition

// >>> hdl/dual_timebase_pkg.sv
package dual_timebase_pkg;

  // register offsets, kept as printed indices
  localparam logic [15:0] OPERATING_MODE_OFS   = 16'h251c;
  localparam logic [15:0] TOTAL_SAMPLE_OFS     = 16'h2710;
  localparam logic [15:0] SEGMENT_LENGTH_OFS   = 16'h271a;
  localparam logic [15:0] SEGMENT_COUNT_OFS    = 16'h2724;
  localparam logic [15:0] AFTER_TRIGGER_OFS    = 16'h272e;
  localparam logic [15:0] SLOW_DIVIDER_OFS     = 16'h2738;
  localparam logic [15:0] ACQ_STATUS_OFS       = 16'h2742;

  // operating mode codes
  localparam logic [31:0] CONTINUOUS_DUAL_TIMEBASE = 32'h0000_0080;
  localparam logic [31:0] STANDARD_DUAL_TIMEBASE   = 32'h0000_0100;

  // reset values
  localparam logic [31:0] MODE_RESET    = STANDARD_DUAL_TIMEBASE;
  localparam logic [63:0] TOTAL_RESET   = 64'h0000_0000_0000_0040;
  localparam logic [63:0] SEGMENT_RESET = 64'h0000_0000_0000_0010;
  localparam logic [63:0] COUNT_RESET   = 64'h0000_0000_0000_0000;
  localparam logic [63:0] AFTER_RESET   = 64'h0000_0000_0000_0008;
  localparam logic [31:0] DIVIDER_RESET = 32'h0000_0008;

  // limits, in samples or clocks
  localparam logic [31:0] DIV_MIN_WIDE    = 32'h0000_0008;
  localparam logic [31:0] DIV_MAX_WIDE    = 32'h0002_0000 - 32'h0000_0008;
  localparam logic [31:0] DIV_MIN_NARROW  = 32'h0000_0010;
  localparam logic [31:0] DIV_MAX_NARROW  = 32'h0004_0000 - 32'h0000_0010;
  localparam logic [63:0] SAMPLE_STEP     = 64'h0000_0000_0000_0008;
  localparam logic [63:0] SEGMENT_MIN     = 64'h0000_0000_0000_0010;
  localparam logic [63:0] AFTER_MIN       = 64'h0000_0000_0000_0008;
  localparam logic [63:0] PRE_MIN         = 64'h0000_0000_0000_0008;
  localparam logic [63:0] PRE_MAX_ONE_CH  = 64'h0000_0000_0000_2000;
  localparam logic [63:0] PRE_MAX_TWO_CH  = 64'h0000_0000_0000_1000;

  // status bit positions
  localparam int RUNNING_BIT  = 0;
  localparam int FINISHED_BIT = 1;
  localparam int PRETRIG_BIT  = 2;
  localparam int DIVIDER_BIT  = 3;
  localparam int SETUP_BIT    = 4;

  localparam int SAMPLE_W = 14;

  typedef enum logic [1:0] {
    ACQ_IDLE = 2'b00,
    ACQ_RUN  = 2'b01,
    ACQ_DONE = 2'b10
  } acq_state_e;

  typedef struct packed {
    logic                valid;
    logic                last;
    logic [SAMPLE_W-1:0] data;
  } sample_beat_s;

endpackage : dual_timebase_pkg

// >>> testbench/host_model.sv
`timescale 1ns/10ps
// host software stand-in: one-cycle strobes, released lines show inverted data
module host_model (
  input  wire logic        sys_clk,
  input  wire logic [63:0] reg_rdata,
  input  wire logic        reg_rvalid,
  output logic             reg_write,
  output logic             reg_read,
  output logic      [15:0] reg_addr,
  output logic      [63:0] reg_wdata
);
  initial begin
    reg_write = 1'b0;
    reg_read  = 1'b0;
    reg_addr  = 16'h0000;
    reg_wdata = 64'h0;
  end
  ////////////////////////////////////////
  task automatic wr(input logic [15:0] a, input logic [63:0] d);
    @(posedge sys_clk);
    reg_write <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_write <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
  endtask : wr
  // address held through the taking edge, since read data follows it
  task automatic rd(input logic [15:0] a, output logic [63:0] d, output bit ok);
    @(posedge sys_clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_read <= 1'b0;
    reg_addr <= ~a;
    #1;
    ok = (reg_rvalid === 1'b1);
    d = reg_rdata;
  endtask : rd
endmodule : host_model

// >>> testbench/dual_timebase_acquisition_tb.sv
`timescale 1ns/10ps
module dual_timebase_acquisition_tb import dual_timebase_pkg::*;;
  logic                sys_clk;
  logic                reset;
  logic                reg_write;
  logic                reg_read;
  logic         [15:0] reg_addr;
  logic         [63:0] reg_wdata;
  logic         [63:0] reg_rdata;
  logic                reg_rvalid;
  logic                start_cmd;
  logic                stop_cmd;
  logic                two_channels;
  logic                trigger;
  logic [SAMPLE_W-1:0] sample_in;
  sample_beat_s        fast_out;
  sample_beat_s        slow_out;
  logic                running;
  logic                pretrigger_length_error;
  int                  n_errors;
  int                  compares;
  int                  nseg;
  int                  beat;
  int                  cyc;
  int                  prev_cyc;
  bit                  have_prev;
  bit                  seg_open;
  bit                  ok;
  logic         [63:0] exp_div;
  logic         [63:0] pre;
  logic         [63:0] seg;
  logic         [63:0] rv;
  logic [SAMPLE_W-1:0] trig_val;
  logic [SAMPLE_W-1:0] prev_data;
  logic         [63:0] bad_div [3] = '{64'hc, 64'h20000, 64'h0};

  dual_timebase_acquisition dut (
    .sys_clk(sys_clk), .reset(reset), .reg_write(reg_write), .reg_read(reg_read),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .start_cmd(start_cmd), .stop_cmd(stop_cmd),
    .two_channels(two_channels), .trigger(trigger), .sample_in(sample_in),
    .fast_out(fast_out), .slow_out(slow_out), .running(running),
    .pretrigger_length_error(pretrigger_length_error)
  );
  host_model host (
    .sys_clk(sys_clk), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .reg_write(reg_write), .reg_read(reg_read), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata)
  );
  ////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  // counting samples make the fast window position visible
  // the trigger sample itself closes the pretrigger part
  always @(posedge sys_clk) sample_in <= sample_in + 14'h0001;
  always @(posedge sys_clk) begin
    cyc = cyc + 1;
    if (trigger === 1'b1 && !seg_open) begin
      trig_val = sample_in;
      seg_open = 1'b1;
    end
    if (fast_out.valid === 1'b1) begin
      check({50'h0, fast_out.data},
            {50'h0, (beat == 0) ? trig_val - pre[13:0] + 14'h0001 : prev_data + 14'h0001});
      prev_data = fast_out.data;
      beat = beat + 1;
      if (fast_out.last === 1'b1) begin
        check(64'(beat), seg);
        beat = 0;
        nseg = nseg + 1;
        seg_open = 1'b0;
      end
    end
    if (slow_out.valid === 1'b1) begin
      if (have_prev) check(64'(cyc - prev_cyc), exp_div);
      check({49'h0, slow_out.last, slow_out.data}, {50'h0, sample_in - 14'h0001});
      have_prev = 1'b1;
      prev_cyc = cyc;
    end
    if (running !== 1'b1) have_prev = 1'b0;
  end
  ////////////////////////////////////////
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    compares = compares + 1;
    if (seen !== exp) begin
      n_errors = n_errors + 1;
      $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  task automatic end_of_test;
    $display("mismatches %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_of_test
  task automatic rd_check(input logic [15:0] a, input logic [63:0] exp);
    host.rd(a, rv, ok);
    check({63'h0, ok}, 64'h1);
    check(rv, exp);
  endtask : rd_check
  task automatic stat_bit(input int b, input logic e);
    host.rd(ACQ_STATUS_OFS, rv, ok);
    check({63'h0, rv[b]}, {63'h0, e});
  endtask : stat_bit
  task automatic pulse_cmd(input bit go);
    @(posedge sys_clk);
    start_cmd <= go;
    stop_cmd  <= !go;
    @(posedge sys_clk);
    start_cmd <= 1'b0;
    stop_cmd  <= 1'b0;
    #1;
  endtask : pulse_cmd
  task automatic trig;
    @(posedge sys_clk);
    trigger <= 1'b1;
    @(posedge sys_clk);
    trigger <= 1'b0;
  endtask : trig
  task automatic wait_segs(input int n);
    for (int i = 0; i < 400; i++) begin
      if (nseg >= n) return;
      @(posedge sys_clk);
    end
    n_errors = n_errors + 1;
    $display("[FAIL] %0t segment wait ran out", $time);
    end_of_test();
  endtask : wait_segs
  task automatic setup(input logic [31:0] md, input logic [63:0] tot, sg, aft, cnt, dv);
    host.wr(OPERATING_MODE_OFS, {32'h0, md});
    host.wr(TOTAL_SAMPLE_OFS, tot);
    host.wr(SEGMENT_LENGTH_OFS, sg);
    host.wr(SEGMENT_COUNT_OFS, cnt);
    host.wr(AFTER_TRIGGER_OFS, aft);
    host.wr(SLOW_DIVIDER_OFS, dv);
    seg = sg;
    pre = sg - aft;
    exp_div = dv;
    nseg = 0;
    beat = 0;
    seg_open = 1'b0;
  endtask : setup
  task automatic run_check(input logic e);
    check({63'h0, running}, {63'h0, e});
  endtask : run_check
  ////////////////////////////////////////
  initial begin
    repeat (100000) @(posedge sys_clk);
    n_errors = n_errors + 1;
    end_of_test();
  end
  initial begin
    {reset, start_cmd, stop_cmd, two_channels, trigger} = 5'h10;
    {sample_in, nseg, beat, cyc, prev_cyc, have_prev, seg_open} = '0;
    {n_errors, compares, exp_div, pre, seg} = '0;
    repeat (20) @(posedge sys_clk);
    reset <= 1'b0;
    rd_check(OPERATING_MODE_OFS, 64'(MODE_RESET));
    rd_check(TOTAL_SAMPLE_OFS, TOTAL_RESET);
    rd_check(SEGMENT_LENGTH_OFS, SEGMENT_RESET);
    rd_check(SEGMENT_COUNT_OFS, COUNT_RESET);
    rd_check(AFTER_TRIGGER_OFS, AFTER_RESET);
    rd_check(SLOW_DIVIDER_OFS, 64'(DIVIDER_RESET));
    rd_check(16'h2000, 64'h0);
    for (int k = 0; k < 3; k++) begin
      setup(STANDARD_DUAL_TIMEBASE, 64'h40, 64'h20, 64'h10, 64'h0, bad_div[k]);
      pulse_cmd(1'b1);
      run_check(1'b0);
      stat_bit(DIVIDER_BIT, 1'b1);
    end
    setup(32'h0000_0040, 64'h40, 64'h20, 64'h10, 64'h0, 64'h8);
    pulse_cmd(1'b1);
    run_check(1'b0);
    stat_bit(SETUP_BIT, 1'b1);
    setup(STANDARD_DUAL_TIMEBASE, 64'h40, 64'h20, 64'h10, 64'h0, 64'h1fff8);
    pulse_cmd(1'b1);
    run_check(1'b1);
    pulse_cmd(1'b0);
    run_check(1'b0);
    // pretrigger limit: 8192 one channel, 4096 two channels
    setup(STANDARD_DUAL_TIMEBASE, 64'h2010, 64'h2010, 64'h8, 64'h0, 64'h8);
    pulse_cmd(1'b1);
    check({63'h0, pretrigger_length_error}, 64'h1);
    stat_bit(PRETRIG_BIT, 1'b1);
    two_channels <= 1'b1;
    setup(STANDARD_DUAL_TIMEBASE, 64'h1010, 64'h1010, 64'h8, 64'h0, 64'h8);
    pulse_cmd(1'b1);
    check({63'h0, pretrigger_length_error}, 64'h1);
    setup(STANDARD_DUAL_TIMEBASE, 64'h1008, 64'h1008, 64'h8, 64'h0, 64'h8);
    pulse_cmd(1'b1);
    check({63'h0, pretrigger_length_error}, 64'h0);
    run_check(1'b1);
    stat_bit(RUNNING_BIT, 1'b1);
    pulse_cmd(1'b0);
    two_channels <= 1'b0;
    // standard: two segments fill the total, a trigger mid-segment is ignored
    setup(STANDARD_DUAL_TIMEBASE, 64'h40, 64'h20, 64'h10, 64'h0, 64'h8);
    pulse_cmd(1'b1);
    repeat (20) @(posedge sys_clk);
    trig();
    repeat (4) @(posedge sys_clk);
    trig();
    wait_segs(1);
    trig();
    wait_segs(2);
    repeat (3) @(posedge sys_clk);
    #1;
    run_check(1'b0);
    stat_bit(FINISHED_BIT, 1'b1);
    trig();
    repeat (40) @(posedge sys_clk);
    check(64'(nseg), 64'h2);
    // continuous with a count of two; a write in mid-run is dropped
    setup(CONTINUOUS_DUAL_TIMEBASE, 64'h40, 64'h20, 64'h10, 64'h2, 64'h10);
    pulse_cmd(1'b1);
    repeat (20) @(posedge sys_clk);
    trig();
    wait_segs(1);
    host.wr(SEGMENT_LENGTH_OFS, 64'h30);
    trig();
    wait_segs(2);
    repeat (3) @(posedge sys_clk);
    #1;
    run_check(1'b0);
    rd_check(SEGMENT_LENGTH_OFS, 64'h20);
    // count zero runs until stopped
    setup(CONTINUOUS_DUAL_TIMEBASE, 64'h40, 64'h20, 64'h10, 64'h0, 64'h8);
    pulse_cmd(1'b1);
    repeat (20) @(posedge sys_clk);
    for (int k = 1; k <= 3; k++) begin
      trig();
      wait_segs(k);
    end
    run_check(1'b1);
    pulse_cmd(1'b0);
    run_check(1'b0);
    end_of_test();
  end
endmodule : dual_timebase_acquisition_tb
